// File: shared/its_pkg.sv
// Contract
// - After reset the converter runs at 9-bit resolution with no bus access.
// - Conversions start at reset release and repeat without any command.
// - Resolution selectable 9, 10, 11 or 12 bits; unused result LSBs read zero.
// - Result is in degrees Celsius; no Fahrenheit conversion in hardware.
// - Master reads latest result and every setting register over the serial port.
// - Serial port works with master clocking up to 400 kHz; master stays below.
// - Three strap inputs give the three low bits of the slave address.
// - Data line is bidirectional; clock line is an input driven by master.
// - Alert pin is open drain: pulled low or released only.
// - Alert offers comparator and interrupt behaviour, chosen by configuration.
// - Result compared with 16-bit read/write over-limit and hysteresis thresholds.
// - Alert activates when temperature exceeds limits, per selected behaviour.
// - Comparator alert sets after fault count above limit, clears below hysteresis.
// - Interrupt alert clears on shutdown entry or any read; rearms below hysteresis.
// - Fault-count field bits 4:3 selects 1, 2, 4 or 6 conversions; resets 00.
// - Alert active level selected by polarity bit, active-low after reset.
//
// Purpose: shared constants and types of the thermal sensor block
// Assumes: one system clock of 125 MHz
// Notes: pointer codes select the four registers reached over the serial port
package its_pkg;
  localparam int CLK_MHZ = 125;
  // Register pointers
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_HYST = 2'h2;
  localparam logic [1:0] PTR_OVER = 2'h3;
  // Configuration fields
  localparam int CFG_SD = 0;
  localparam int CFG_MODE = 1;
  localparam int CFG_POL = 2;
  localparam int CFG_FT_LO = 3;
  localparam int CFG_FT_HI = 4;
  localparam int CFG_RES_LO = 5;
  localparam int CFG_RES_HI = 6;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [1:0] RES_9 = 2'h0;
  localparam logic [15:0] OVER_RST = 16'h7f00;
  localparam logic [15:0] HYST_RST = 16'h7e00;
  // Upper four address bits
  localparam logic [3:0] ADDR_BASE = 4'h4;
  // Serial bit slots
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Synchroniser lanes
  localparam int N_IN = 7;
  localparam int IN_SCL = 0;
  localparam int IN_SDA = 1;
  localparam int IN_STRAP = 2;
  localparam int IN_WR = 5;
  localparam int IN_RD = 6;
  localparam logic [6:0] LVL_RST = 7'h03;

  typedef enum logic [2:0] {
    ST_ADDR = 3'h0,
    ST_PTR = 3'h1,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h2,
    ST_SKIP = 3'h6
  } its_link_e;

  function automatic logic [15:0] res_mask(input logic [1:0] res);
    unique case (res)
      2'h0: res_mask = 16'hff80;
      2'h1: res_mask = 16'hffc0;
      2'h2: res_mask = 16'hffe0;
      2'h3: res_mask = 16'hfff0;
    endcase
  endfunction

  function automatic logic [2:0] fault_need(input logic [1:0] ft);
    unique case (ft)
      2'h0: fault_need = 3'h1;
      2'h1: fault_need = 3'h2;
      2'h2: fault_need = 3'h4;
      2'h3: fault_need = 3'h6;
    endcase
  endfunction
endpackage

// File: shared/its_link_if.sv
// Purpose: carries words and events between the core and the serial link
// Assumes: snapshots are frozen while a frame is open
// Notes: write and read events are toggles held until the next event
`timescale 1ns/1ns
interface its_link_if;
  logic sys_rst;
  logic link_rst;
  logic [2:0] strap;
  logic [15:0] snap_temp;
  logic [15:0] snap_hyst;
  logic [15:0] snap_over;
  logic [7:0] snap_cfg;
  logic wr_tgl;
  logic [1:0] wr_ptr;
  logic [15:0] wr_data;
  logic rd_tgl;
  modport core (
    output sys_rst, link_rst, strap, snap_temp, snap_hyst, snap_over, snap_cfg,
    input wr_tgl, wr_ptr, wr_data, rd_tgl
  );
  modport link (
    input sys_rst, link_rst, strap, snap_temp, snap_hyst, snap_over, snap_cfg,
    output wr_tgl, wr_ptr, wr_data, rd_tgl
  );
endinterface

// File: core/its_link.sv
// Purpose: serial slave clocked by the master's serial clock
// Assumes: link_rst is high outside frames and pulses at every start
// Notes: samples data on rising edges, drives data line on falling edges
`timescale 1ns/1ns
module its_link import its_pkg::*; (
  // Serial pins
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_oe,
  // Core side
  its_link_if.link lk
);
  its_link_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] hi_q;
  logic [1:0] ptr_q;
  logic ack_q;
  logic msb_q;
  logic wr_tgl_q;
  logic rd_tgl_q;
  logic [1:0] wr_ptr_q;
  logic [15:0] wr_data_q;
  logic [7:0] byte_w;
  logic match_w;
  logic [15:0] rd_word;

  assign byte_w = {sh_q[6:0], sda_i};
  assign match_w = (byte_w[7:1] == {ADDR_BASE, lk.strap});
  assign lk.wr_tgl = wr_tgl_q;
  assign lk.wr_ptr = wr_ptr_q;
  assign lk.wr_data = wr_data_q;
  assign lk.rd_tgl = rd_tgl_q;

  always_comb begin
    unique case (ptr_q)
      PTR_TEMP: rd_word = lk.snap_temp;
      PTR_CFG: rd_word = {lk.snap_cfg, lk.snap_cfg};
      PTR_HYST: rd_word = lk.snap_hyst;
      PTR_OVER: rd_word = lk.snap_over;
    endcase
  end

  // Bit slot counter and shifter, sampled on rising clock
  always_ff @(posedge scl or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
    end else begin
      cnt_q <= (cnt_q == BIT_ACK) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q != BIT_ACK) begin
        sh_q <= byte_w;
      end
    end
  end

  // Transfer state
  always_ff @(posedge scl or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      st_q <= ST_ADDR;
      ack_q <= 1'b0;
      tx_q <= 8'h00;
      msb_q <= 1'b1;
    end else if (cnt_q == BIT_LAST) begin
      ack_q <= (st_q == ST_ADDR) ? match_w : (st_q == ST_PTR || st_q == ST_WDATA);
    end else if (cnt_q == BIT_ACK) begin
      unique case (st_q)
        ST_ADDR: begin
          if (!ack_q) begin
            st_q <= ST_SKIP;
          end else if (sh_q[0]) begin
            st_q <= ST_RDATA;
            tx_q <= rd_word[15:8];
            msb_q <= 1'b0;
          end else begin
            st_q <= ST_PTR;
          end
        end
        ST_PTR: st_q <= ST_WDATA;
        ST_WDATA: msb_q <= !msb_q;
        ST_RDATA: begin
          if (sda_i) begin
            st_q <= ST_SKIP;
          end else begin
            tx_q <= msb_q ? rd_word[15:8] : rd_word[7:0];
            msb_q <= !msb_q;
          end
        end
        ST_SKIP: st_q <= ST_SKIP;
        default: st_q <= ST_SKIP;
      endcase
    end
  end

  // Pointer and write words persist across frames
  always_ff @(posedge scl or posedge lk.sys_rst) begin
    if (lk.sys_rst) begin
      ptr_q <= PTR_TEMP;
      hi_q <= 8'h00;
      wr_ptr_q <= PTR_TEMP;
      wr_data_q <= 16'h0000;
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
    end else if (!lk.link_rst && cnt_q == BIT_ACK && ack_q) begin
      unique case (st_q)
        ST_ADDR: rd_tgl_q <= sh_q[0] ? !rd_tgl_q : rd_tgl_q;
        ST_PTR: ptr_q <= sh_q[1:0];
        ST_WDATA: begin
          if (ptr_q == PTR_CFG || !msb_q) begin
            wr_ptr_q <= ptr_q;
            wr_data_q <= (ptr_q == PTR_CFG) ? {8'h00, sh_q} : {hi_q, sh_q};
            wr_tgl_q <= !wr_tgl_q;
          end else begin
            hi_q <= sh_q;
          end
        end
        default: hi_q <= hi_q;
      endcase
    end
  end

  // Data line drive, changed on falling clock
  always_ff @(negedge scl or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      sda_oe <= 1'b0;
    end else if (cnt_q == BIT_ACK) begin
      sda_oe <= ack_q;
    end else begin
      sda_oe <= (st_q == ST_RDATA) && !tx_q[~cnt_q[2:0]];
    end
  end

  chk_addr_ack_match: assert property (
    @(posedge scl) disable iff (lk.link_rst)
    (st_q == ST_ADDR && cnt_q == BIT_LAST) |=> (ack_q == $past(match_w)))
    else $error("address acknowledge does not follow strap match");
endmodule

// File: core/its_thermo.sv
// Purpose: fault queue and alarm state of the thermostat
// Assumes: conv_done pulses once per finished conversion
// Notes: hunt_lo_q tells whether the queue watches the hysteresis side
`timescale 1ns/1ns
module its_thermo import its_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Conversion
  input wire logic conv_done,
  input wire logic signed [15:0] temp,
  input wire logic signed [15:0] over,
  input wire logic signed [15:0] hyst,
  // Settings and events
  input wire logic mode_int,
  input wire logic shutdown,
  input wire logic rd_ev,
  input wire logic [1:0] ft,
  // Alarm
  output logic active_q
);
  logic [2:0] cnt_q;
  logic hunt_lo_q;
  logic sd_prev_q;
  logic hit_w;
  logic full_w;
  logic [2:0] need_w;

  assign hit_w = hunt_lo_q ? (temp < hyst) : (temp > over);
  assign need_w = (!mode_int && active_q) ? 3'h1 : fault_need(ft);
  assign full_w = conv_done && hit_w && ((cnt_q + 3'h1) >= need_w);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
    end else if (conv_done) begin
      cnt_q <= (hit_w && !full_w) ? cnt_q + 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hunt_lo_q <= 1'b0;
      sd_prev_q <= 1'b0;
    end else begin
      hunt_lo_q <= full_w ? !hunt_lo_q : hunt_lo_q;
      sd_prev_q <= shutdown;
    end
  end

  // Interrupt mode: a new fault wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
    end else if (mode_int) begin
      if (full_w) begin
        active_q <= 1'b1;
      end else if (rd_ev || (shutdown && !sd_prev_q)) begin
        active_q <= 1'b0;
      end
    end else if (full_w) begin
      active_q <= !active_q;
    end
  end

  chk_cmp_release: assert property (
    @(posedge mclk) disable iff (rst)
    (!mode_int && active_q && hunt_lo_q && conv_done && temp < hyst) |=> !active_q)
    else $error("comparator alert did not clear below hysteresis");

  chk_int_read_clear: assert property (
    @(posedge mclk) disable iff (rst)
    (mode_int && active_q && rd_ev && !full_w) |=> !active_q)
    else $error("interrupt alert not cleared by a read");

  chk_fault_need: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(active_q) |-> ($past(conv_done) && ($past(cnt_q) + 3'h1 >= fault_need($past(ft)))))
    else $error("alert set before fault count reached");
endmodule

// File: core/its_top.sv
// Purpose: thermal sensor digital core with serial slave and alarm output
// Assumes: temp_sample is a signed Celsius value on mclk, LSB 1/16 degree
// Notes: serial link runs on scl; frames are framed by start and stop seen on mclk
`timescale 1ns/1ns
module its_top import its_pkg::*; #(
  parameter int CONV_TIME_US = 1000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial port
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address straps
  input wire logic addr_strap_bit2,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit0,
  // Converter front end
  input wire logic [15:0] temp_sample,
  // Alarm pin
  output logic over_limit_alert_out,
  output logic over_limit_alert_out_oe
);
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int CONV_W = $clog2(CONV_CYCLES);
  localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYCLES - 1);

  its_link_if lk ();

  logic [N_IN-1:0] pin_w;
  logic [N_IN-1:0] lvl_w;
  logic [N_IN-1:0] chg_w;
  logic start_w;
  logic stop_w;
  logic idle_q;
  logic link_rst_q;
  logic [2:0] strap_q;
  logic wr_ev_w;
  logic rd_ev_w;
  logic [7:0] cfg_q;
  logic [15:0] over_q;
  logic [15:0] hyst_q;
  logic [15:0] temp_q;
  logic [CONV_W-1:0] conv_cnt_q;
  logic conv_done_q;
  logic [1:0] res_w;
  logic pol_w;
  logic active_w;
  logic [15:0] snap_temp_q;
  logic [15:0] snap_hyst_q;
  logic [15:0] snap_over_q;
  logic [7:0] snap_cfg_q;
  logic alert_oe_q;

  assign res_w = cfg_q[CFG_RES_HI:CFG_RES_LO];
  assign pol_w = cfg_q[CFG_POL];

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // A lane's level changes only once its second and third stages agree
  assign pin_w = {lk.rd_tgl, lk.wr_tgl, addr_strap_bit2, addr_strap_bit1,
                  addr_strap_bit0, sda_i, scl};

  for (genvar i = 0; i < N_IN; i++) begin : g_sync
    logic [2:0] s_q;
    logic l_q;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        s_q <= {3{LVL_RST[i]}};
      end else begin
        s_q <= {s_q[1:0], pin_w[i]};
      end
    end
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        l_q <= LVL_RST[i];
      end else if (s_q[1] == s_q[2]) begin
        l_q <= s_q[2];
      end
    end
    assign lvl_w[i] = l_q;
    assign chg_w[i] = (s_q[1] == s_q[2]) && (s_q[2] != l_q);
  end

  assign wr_ev_w = chg_w[IN_WR];
  assign rd_ev_w = chg_w[IN_RD];

  // ------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------
  // Data edges while the clock line stays high mark start and stop;
  // a data change seen together with a clock fall is an ordinary bit
  assign start_w = chg_w[IN_SDA] && lvl_w[IN_SDA] && lvl_w[IN_SCL] && !chg_w[IN_SCL];
  assign stop_w = chg_w[IN_SDA] && !lvl_w[IN_SDA] && lvl_w[IN_SCL] && !chg_w[IN_SCL];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idle_q <= 1'b1;
    end else if (start_w) begin
      idle_q <= 1'b0;
    end else if (stop_w) begin
      idle_q <= 1'b1;
    end
  end

  // Link logic is held between frames and restarted at every start
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_rst_q <= 1'b1;
    end else begin
      link_rst_q <= start_w || stop_w || idle_q;
    end
  end

  // Straps settle only while the bus is idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_q <= 3'h0;
    end else if (idle_q) begin
      strap_q <= lvl_w[IN_STRAP+2:IN_STRAP];
    end
  end

  // ------------------------------------------------------------
  // Registers written over the serial port
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RST;
    end else if (wr_ev_w && lk.wr_ptr == PTR_CFG) begin
      cfg_q <= lk.wr_data[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      over_q <= OVER_RST;
    end else if (wr_ev_w && lk.wr_ptr == PTR_OVER) begin
      over_q <= lk.wr_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hyst_q <= HYST_RST;
    end else if (wr_ev_w && lk.wr_ptr == PTR_HYST) begin
      hyst_q <= lk.wr_data;
    end
  end

  // ------------------------------------------------------------
  // Conversion cycle
  // ------------------------------------------------------------
  // Free running from reset release; stopped only by shutdown
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_cnt_q <= '0;
    end else if (cfg_q[CFG_SD] || conv_cnt_q == CONV_LAST) begin
      conv_cnt_q <= '0;
    end else begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_done_q <= 1'b0;
    end else begin
      conv_done_q <= !cfg_q[CFG_SD] && conv_cnt_q == CONV_LAST;
    end
  end

  // Result kept in Celsius; unused LSBs forced to zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      temp_q <= 16'h0000;
    end else if (!cfg_q[CFG_SD] && conv_cnt_q == CONV_LAST) begin
      temp_q <= temp_sample & res_mask(res_w);
    end
  end

  // ------------------------------------------------------------
  // Thermostat
  // ------------------------------------------------------------
  its_thermo u_thermo (
    .mclk(mclk),
    .rst(rst),
    .conv_done(conv_done_q),
    .temp(temp_q),
    .over(over_q & res_mask(res_w)),
    .hyst(hyst_q & res_mask(res_w)),
    .mode_int(cfg_q[CFG_MODE]),
    .shutdown(cfg_q[CFG_SD]),
    .rd_ev(rd_ev_w),
    .ft(cfg_q[CFG_FT_HI:CFG_FT_LO]),
    .active_q(active_w)
  );

  // Open drain: pulled low when the level to show is low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alert_oe_q <= 1'b0;
    end else begin
      alert_oe_q <= active_w ^ pol_w;
    end
  end

  assign over_limit_alert_out = 1'b0;
  assign over_limit_alert_out_oe = alert_oe_q;

  // ------------------------------------------------------------
  // Crossing to the link domain
  // ------------------------------------------------------------
  // Snapshots follow the registers only while no frame is open
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      snap_temp_q <= 16'h0000;
      snap_hyst_q <= HYST_RST;
      snap_over_q <= OVER_RST;
      snap_cfg_q <= CFG_RST;
    end else if (link_rst_q) begin
      snap_temp_q <= temp_q;
      snap_hyst_q <= hyst_q;
      snap_over_q <= over_q;
      snap_cfg_q <= cfg_q;
    end
  end

  assign lk.sys_rst = rst;
  assign lk.link_rst = link_rst_q;
  assign lk.strap = strap_q;
  assign lk.snap_temp = snap_temp_q;
  assign lk.snap_hyst = snap_hyst_q;
  assign lk.snap_over = snap_over_q;
  assign lk.snap_cfg = snap_cfg_q;

  // ------------------------------------------------------------
  // Serial link
  // ------------------------------------------------------------
  its_link u_link (
    .scl(scl),
    .sda_i(sda_i),
    .sda_oe(sda_oe),
    .lk(lk)
  );

  assign sda_o = 1'b0;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_cfg_power_default: assert property (
    @(posedge mclk) disable iff (rst)
    $past(rst) |-> (res_w == RES_9 && cfg_q == CFG_RST))
    else $error("configuration not at 9-bit default after reset");

  chk_conv_free_run: assert property (
    @(posedge mclk) disable iff (rst)
    (!cfg_q[CFG_SD] && conv_cnt_q != CONV_LAST)
      |=> (conv_cnt_q == $past(conv_cnt_q) + 1'b1))
    else $error("conversion counter stalled while running");

  chk_result_lsbs: assert property (
    @(posedge mclk) disable iff (rst)
    conv_done_q |-> ((temp_q & ~res_mask($past(res_w))) == 16'h0000))
    else $error("result holds bits below the resolution");

  chk_threshold_write: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_ev_w && lk.wr_ptr == PTR_OVER) |=> (over_q == $past(lk.wr_data)))
    else $error("over-limit write did not land");

  chk_snap_frozen: assert property (
    @(posedge mclk) disable iff (rst)
    !link_rst_q |=> ($stable(snap_temp_q) && $stable(snap_cfg_q)))
    else $error("snapshot changed during an open frame");

  chk_alert_drive: assert property (
    @(posedge mclk) disable iff (rst)
    1'b1 |=> (over_limit_alert_out_oe == ($past(active_w) ^ $past(pol_w))
              && over_limit_alert_out == 1'b0))
    else $error("alert pin does not follow state and polarity");

  chk_frame_restart: assert property (
    @(posedge mclk) disable iff (rst)
    start_w |=> link_rst_q ##1 !link_rst_q)
    else $error("link not restarted by a start");
endmodule

// File: bench/its_master.sv
// Purpose: two-wire bus master model that drives the serial clock and data
// Assumes: the data wire has a pull-up; the clock stands high between frames
// Notes: the testbench calls the tasks; data changes mid low phase of the clock
`timescale 1ns/1ns
module its_master #(
  parameter int HALF = 1254
) (
  // Bus lines
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Start or repeated start
  task automatic start();
    sda_m = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_m = 1'b0;
    #HALF scl = 1'b0;
  endtask

  task automatic stop();
    #(HALF/2) sda_m = 1'b0;
    #(HALF/2) scl = 1'b1;
    #HALF sda_m = 1'b1;
    #HALF;
  endtask

  // One clock period; the wire is sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #(HALF/2) sda_m = b;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) r = sda;
    #(HALF/2) scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Last byte of a read is answered with a no-acknowledge
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench of the thermal sensor core over its serial port
// Assumes: conversion time shortened to 125 cycles
// Notes: device address uses straps 3'h5
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module testbench import its_pkg::*; ;
  localparam logic [6:0] DEV = {ADDR_BASE, 3'h5};
  logic mclk, rst, scl, sda_m, sda_o, sda_oe, alert_o, alert_oe;
  logic [2:0] strap;
  logic [15:0] temp_sample;
  logic [15:0] d;
  wire logic sda_w;
  wire logic alert_w;
  int n_errors, samples_checked;

  assign sda_w = sda_oe ? (sda_m & sda_o) : sda_m;
  assign alert_w = alert_oe ? alert_o : 1'b1;

  its_top #(.CONV_TIME_US(1)) its_top_inst (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_bit2(strap[2]), .addr_strap_bit1(strap[1]), .addr_strap_bit0(strap[0]),
    .temp_sample(temp_sample), .over_limit_alert_out(alert_o),
    .over_limit_alert_out_oe(alert_oe)
  );
  its_master its_master_inst (.scl(scl), .sda_m(sda_m), .sda(sda_w));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic exp);
    logic a;
    its_master_inst.wbyte(b, a);
    `CHK(a, exp)
  endtask

  task automatic wr(input logic [1:0] p, input logic [15:0] v, input int n);
    its_master_inst.start();
    send({DEV, 1'b0}, 1'b1);
    send({6'h00, p}, 1'b1);
    if (n == 2) send(v[15:8], 1'b1);
    send(v[7:0], 1'b1);
    its_master_inst.stop();
  endtask

  task automatic rd(input logic setp, input logic [1:0] p, input int n,
                    output logic [15:0] v);
    if (setp) begin
      its_master_inst.start();
      send({DEV, 1'b0}, 1'b1);
      send({6'h00, p}, 1'b1);
    end
    its_master_inst.start();
    send({DEV, 1'b1}, 1'b1);
    v = 16'h0000;
    if (n == 2) its_master_inst.rbyte(1'b0, v[15:8]);
    its_master_inst.rbyte(1'b1, v[7:0]);
    its_master_inst.stop();
  endtask

  task automatic wait_alert(input logic exp);
    for (int k = 0; k < 1000 && alert_oe !== exp; k++) @(negedge mclk);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    temp_sample = 16'h1a5f;
    strap = 3'h5;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(negedge mclk);
    `CHK(alert_oe, 1'b0)
    `CHK(sda_oe, 1'b0)
    rst = 1'b0;
    repeat (300) @(negedge mclk);
    `CHK(alert_w, 1'b1)
    its_master_inst.start();
    send({ADDR_BASE, 3'h4, 1'b0}, 1'b0);
    its_master_inst.stop();
    rd(1'b1, PTR_CFG, 1, d);
    `CHK(d[7:0], 8'h00)
    rd(1'b1, PTR_OVER, 2, d);
    `CHK(d, 16'h7f00)
    wr(PTR_HYST, 16'h1800, 2);
    wr(PTR_OVER, 16'h1900, 2);
    wait_alert(1'b1);
    `CHK(alert_w, 1'b0)
    rd(1'b1, PTR_TEMP, 2, d);
    `CHK(d, 16'h1a00)
    `CHK(alert_oe, 1'b1)
    @(negedge mclk);
    temp_sample = 16'hf000;
    wait_alert(1'b0);
    `CHK(alert_oe, 1'b0)
    wr(PTR_CFG, 16'h0062, 1);
    @(negedge mclk);
    temp_sample = 16'h1a5f;
    wait_alert(1'b1);
    `CHK(alert_oe, 1'b1)
    rd(1'b0, PTR_CFG, 1, d);
    `CHK(d[7:0], 8'h62)
    repeat (400) @(negedge mclk);
    `CHK(alert_oe, 1'b0)
    wr(PTR_CFG, 16'h0066, 1);
    repeat (50) @(negedge mclk);
    `CHK(alert_oe, 1'b1)
    give_verdict();
  end

  // Watchdog: the tests need about 0.8 ms
  initial begin
    #850_000;
    n_errors++;
    give_verdict();
  end
endmodule
